// ### cbsel_mux.sv
// Top of the configurable pin function multiplexer with APB register access
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "cbsel_regs.svh"

module cbsel_mux (
    input wire logic pclk, // System clock, 200 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic [11:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic nv_load, // Configuration store load pulse
    input wire logic [19:0] nv_func_sel, // Stored function codes
    input wire logic nv_cancel_sleep, // Stored cancel-sleep option
    input wire logic usb_configured, // Host has configured device
    input wire logic usb_suspend_req, // Bus idle asks for suspend
    input wire logic usb_tx_act, // USB transmit activity pulse
    input wire logic usb_rx_act, // USB receive activity pulse
    input wire logic usb_sof, // Start-of-frame received pulse
    input wire logic charger_port, // Dedicated charger detected
    input wire logic rs485_tx_active, // UART transmitting
    input wire logic bb_wr_strobe_n, // Bit-bang write strobe
    input wire logic bb_rd_strobe_n, // Bit-bang read strobe
    input wire logic [3:0] config_pin_in, // Pad input levels
    output logic [3:0] config_pin_out, // Pad output levels
    output logic [3:0] config_pin_oe, // Pad output enables
    output logic suspend_active, // Device in suspend
    output logic bus_power_present // Bus power sensed
);
    localparam int NP = `CBSEL_NPINS;
    localparam int FW = `CBSEL_FW;
    localparam logic [`CBSEL_LED_CW-1:0] LED_LOAD = `CBSEL_LED_CW'(`CBSEL_LED_CYCLES);

    logic [NP*FW-1:0] func_q;
    logic cancel_q;
    logic [NP-1:0] gpio_out_q;
    logic [NP-1:0] gpio_dir_q;
    logic suspend_q;
    logic keep_low_q;
    logic vbus_q;
    logic configured_q;
    logic charger_q;
    logic txen_q;
    logic wr_n_q;
    logic rd_n_q;
    logic tstamp_q;
    logic [`CBSEL_LED_CW-1:0] tx_cnt_q;
    logic [`CBSEL_LED_CW-1:0] rx_cnt_q;
    logic clk_fast;
    logic clk_mid;
    logic clk_slow;
    logic [31:0] rdata_d;
    logic wr_fire;
    logic setup;
    cbsel_pkg::cbsel_core_t core;

    // ==========================================================
    // Helpers
    function automatic logic addr_hit(input logic [11:0] a);
        if (a == `CBSEL_FUNC_ADDR) begin
            addr_hit = 1'b1;
        end else if (a == `CBSEL_CTRL_ADDR) begin
            addr_hit = 1'b1;
        end else if (a == `CBSEL_GPIO_ADDR) begin
            addr_hit = 1'b1;
        end else if (a == `CBSEL_STAT_ADDR) begin
            addr_hit = 1'b1;
        end else begin
            addr_hit = 1'b0;
        end
    endfunction

    // True when some pin with this function sits at the given level
    function automatic logic pin_sees(input logic [NP*FW-1:0] f, input logic [4:0] fn,
            input logic [NP-1:0] lvl, input logic want);
        pin_sees = 1'b0;
        for (int i = 0; i < NP; i++) begin
            if (f[i*FW +: FW] == fn && lvl[i] == want) begin
                pin_sees = 1'b1;
            end
        end
    endfunction

    // True when at least one pin has this function
    function automatic logic fn_used(input logic [NP*FW-1:0] f, input logic [4:0] fn);
        fn_used = 1'b0;
        for (int i = 0; i < NP; i++) begin
            if (f[i*FW +: FW] == fn) begin
                fn_used = 1'b1;
            end
        end
    endfunction

    // Retrigger on activity, else count down
    function automatic logic [`CBSEL_LED_CW-1:0] led_next(
            input logic [`CBSEL_LED_CW-1:0] c, input logic act);
        if (act) begin
            led_next = LED_LOAD;
        end else if (c != '0) begin
            led_next = c - `CBSEL_LED_CW'(1);
        end else begin
            led_next = '0;
        end
    endfunction

    // ==========================================================
    // APB slave
    assign setup = psel && !penable;
    assign wr_fire = psel && penable && pready && pwrite;

    always_comb begin
        rdata_d = '0;
        if (paddr == `CBSEL_FUNC_ADDR) begin
            rdata_d[NP*FW-1:0] = func_q;
        end else if (paddr == `CBSEL_CTRL_ADDR) begin
            rdata_d[`CBSEL_CTRL_CANCEL_BIT] = cancel_q;
        end else if (paddr == `CBSEL_GPIO_ADDR) begin
            rdata_d[NP-1:0] = gpio_out_q;
            rdata_d[`CBSEL_GPIO_DIR_LSB +: NP] = gpio_dir_q;
        end else if (paddr == `CBSEL_STAT_ADDR) begin
            rdata_d[NP-1:0] = config_pin_in;
            rdata_d[4] = suspend_q;
            rdata_d[5] = configured_q;
            rdata_d[6] = charger_q;
            rdata_d[7] = vbus_q;
            rdata_d[8] = keep_low_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup && !addr_hit(paddr);
            if (setup && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end

    // ==========================================================
    // Function selection and options
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_q <= `CBSEL_FUNC_RESET;
            cancel_q <= `CBSEL_CTRL_RESET;
        end else if (nv_load) begin
            func_q <= nv_func_sel;
            cancel_q <= nv_cancel_sleep;
        end else if (wr_fire && paddr == `CBSEL_FUNC_ADDR) begin
            func_q <= pwdata[NP*FW-1:0];
        end else if (wr_fire && paddr == `CBSEL_CTRL_ADDR) begin
            cancel_q <= pwdata[`CBSEL_CTRL_CANCEL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {gpio_dir_q, gpio_out_q} <= `CBSEL_GPIO_RESET;
        end else if (wr_fire && paddr == `CBSEL_GPIO_ADDR) begin
            gpio_out_q <= pwdata[NP-1:0];
            gpio_dir_q <= pwdata[`CBSEL_GPIO_DIR_LSB +: NP];
        end
    end

    // ==========================================================
    // Input functions and suspend
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keep_low_q <= 1'b0;
            vbus_q <= 1'b0;
            suspend_q <= 1'b0;
        end else begin
            keep_low_q <= pin_sees(func_q, cbsel_pkg::FN_KEEP_AWAKE_N, config_pin_in, 1'b0);
            vbus_q <= !fn_used(func_q, cbsel_pkg::FN_BUS_SENSE)
                || pin_sees(func_q, cbsel_pkg::FN_BUS_SENSE, config_pin_in, 1'b1);
            suspend_q <= usb_suspend_req && !keep_low_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            suspend_active <= 1'b0;
            bus_power_present <= 1'b0;
        end else begin
            suspend_active <= suspend_q;
            bus_power_present <= vbus_q;
        end
    end

    // ==========================================================
    // Device state sampling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            configured_q <= 1'b0;
            charger_q <= 1'b0;
            txen_q <= 1'b0;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
        end else begin
            configured_q <= usb_configured;
            charger_q <= charger_port;
            txen_q <= rs485_tx_active;
            wr_n_q <= bb_wr_strobe_n;
            rd_n_q <= bb_rd_strobe_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tstamp_q <= 1'b0;
        end else if (usb_sof) begin
            tstamp_q <= ~tstamp_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt_q <= '0;
            rx_cnt_q <= '0;
        end else begin
            tx_cnt_q <= led_next(tx_cnt_q, usb_tx_act);
            rx_cnt_q <= led_next(rx_cnt_q, usb_rx_act);
        end
    end

    // ==========================================================
    // Clock outputs, frozen in suspend
    cbsel_clk_gen u_clk (
        .pclk(pclk),
        .presetn(presetn),
        .run(!suspend_q),
        .clk_fast_q(clk_fast),
        .clk_mid_q(clk_mid),
        .clk_slow_q(clk_slow)
    );

    assign core.configured = configured_q;
    assign core.suspend = suspend_q;
    assign core.tx_led = tx_cnt_q != '0;
    assign core.rx_led = rx_cnt_q != '0;
    assign core.charger = charger_q;
    assign core.cancel_sleep = cancel_q;
    assign core.rs485_txen = txen_q;
    assign core.wr_strobe_n = wr_n_q;
    assign core.rd_strobe_n = rd_n_q;
    assign core.tstamp = tstamp_q;
    assign core.clk_fast = clk_fast;
    assign core.clk_mid = clk_mid;
    assign core.clk_slow = clk_slow;

    // ==========================================================
    // Pin drivers
    for (genvar g = 0; g < NP; g++) begin : g_pin
        cbsel_pin_drv u_drv (
            .pclk(pclk),
            .presetn(presetn),
            .func(cbsel_pkg::cbsel_func_t'(func_q[g*FW +: FW])),
            .core(core),
            .gpio_out(gpio_out_q[g]),
            .gpio_dir(gpio_dir_q[g]),
            .pad_out_q(config_pin_out[g]),
            .pad_oe_q(config_pin_oe[g])
        );
    end

    // ==========================================================
    // Pin checks
    logic [2:0] gap_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= '0;
        end else if (suspend_q || clk_fast != core.clk_fast || $changed(clk_fast)) begin
            gap_q <= '0;
        end else begin
            gap_q <= gap_q + 3'h1;
        end
    end

    chk_pwr_switch_on: assert property (@(posedge pclk) disable iff (!presetn)
        (func_q[4:0] == cbsel_pkg::FN_PWR_SWITCH_N && configured_q && !suspend_q)
        |=> (config_pin_oe[0] && !config_pin_out[0]))
        else $error("power enable not pulled low");
    chk_pwr_switch_off: assert property (@(posedge pclk) disable iff (!presetn)
        (func_q[4:0] == cbsel_pkg::FN_PWR_SWITCH_N && suspend_q) |=> !config_pin_oe[0])
        else $error("power enable not released in suspend");
    chk_pwr_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
        (func_q[4:0] == cbsel_pkg::FN_PWR_SWITCH_N) |=> !config_pin_out[0])
        else $error("power enable drove high");
    chk_sleep_low: assert property (@(posedge pclk) disable iff (!presetn)
        (func_q[9:5] == cbsel_pkg::FN_SLEEP_N && suspend_q && !(cancel_q && charger_q))
        |=> (config_pin_oe[1] && !config_pin_out[1]))
        else $error("sleep indicator not low in suspend");
    chk_sleep_cancel: assert property (@(posedge pclk) disable iff (!presetn)
        (func_q[9:5] == cbsel_pkg::FN_SLEEP_N && cancel_q && charger_q)
        |=> config_pin_out[1])
        else $error("sleep indicator not held high on charger");
    chk_clk_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        suspend_q |=> $stable(clk_fast))
        else $error("clock toggled in suspend");
    chk_clk_rate: assert property (@(posedge pclk) disable iff (!presetn)
        gap_q <= 3'h5)
        else $error("fast clock half period too long");
    chk_led_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (usb_rx_act && func_q[14:10] == cbsel_pkg::FN_ANY_LED_N)
        ##1 (func_q[14:10] == cbsel_pkg::FN_ANY_LED_N)[*2]
        |=> (config_pin_oe[2] && !config_pin_out[2]))
        else $error("activity LED did not pulse");
    chk_tstamp_flip: assert property (@(posedge pclk) disable iff (!presetn)
        (usb_sof && func_q[4:0] == cbsel_pkg::FN_TIMESTAMP
        ##1 func_q[4:0] == cbsel_pkg::FN_TIMESTAMP)
        |=> (config_pin_out[0] != $past(config_pin_out[0])))
        else $error("timestamp did not invert");
    chk_keep_awake: assert property (@(posedge pclk) disable iff (!presetn)
        keep_low_q |=> !suspend_q)
        else $error("suspend entered while kept awake");
    chk_input_hiz: assert property (@(posedge pclk) disable iff (!presetn)
        (func_q[9:5] == cbsel_pkg::FN_BUS_SENSE) |=> !config_pin_oe[1])
        else $error("input function drives pad");
    chk_drive_one: assert property (@(posedge pclk) disable iff (!presetn)
        (func_q[4:0] == cbsel_pkg::FN_DRIVE_1) |=> (config_pin_oe[0] && config_pin_out[0]))
        else $error("constant one not driven");
endmodule

// ### cbsel_regs.svh
// Register offsets, field positions, reset values and timing counts for the pin function mux
`ifndef CBSEL_REGS_SVH
`define CBSEL_REGS_SVH

// ==========================================================
// Register map (byte addresses)
`define CBSEL_FUNC_ADDR 12'h000
`define CBSEL_CTRL_ADDR 12'h004
`define CBSEL_GPIO_ADDR 12'h008
`define CBSEL_STAT_ADDR 12'h00C

// ==========================================================
// Field layout
`define CBSEL_NPINS 4
`define CBSEL_FW 5
`define CBSEL_CTRL_CANCEL_BIT 0
`define CBSEL_GPIO_DIR_LSB 4
`define CBSEL_FUNC_RESET 20'h00000
`define CBSEL_CTRL_RESET 1'h0
`define CBSEL_GPIO_RESET 8'h00

// ==========================================================
// Timing
`define CBSEL_CLK_MHZ 200
`define CBSEL_FAST_MHZ 24
`define CBSEL_LED_PULSE_NS 10000
`define CBSEL_LED_CYCLES ((`CBSEL_LED_PULSE_NS * `CBSEL_CLK_MHZ) / 1000)
`define CBSEL_LED_CW 12
`define CBSEL_ACC_W 8

`endif

// ### cbsel_pkg.sv
// Types shared by the pin function mux files
package cbsel_pkg;

    // Pin function codes
    typedef enum logic [4:0] {
        FN_TRISTATE,
        FN_RS485_TXEN,
        FN_DRIVE_1,
        FN_DRIVE_0,
        FN_PWR_SWITCH_N,
        FN_TX_LED_N,
        FN_RX_LED_N,
        FN_ANY_LED_N,
        FN_SLEEP_N,
        FN_CLK_FAST,
        FN_CLK_MID,
        FN_CLK_SLOW,
        FN_GPIO,
        FN_CHG_HI,
        FN_CHG_LO_N,
        FN_WR_STROBE_N,
        FN_RD_STROBE_N,
        FN_BUS_SENSE,
        FN_TIMESTAMP,
        FN_KEEP_AWAKE_N
    } cbsel_func_t;

    // Internal device state seen by every pin driver
    typedef struct packed {
        logic configured;
        logic suspend;
        logic tx_led;
        logic rx_led;
        logic charger;
        logic cancel_sleep;
        logic rs485_txen;
        logic wr_strobe_n;
        logic rd_strobe_n;
        logic tstamp;
        logic clk_fast;
        logic clk_mid;
        logic clk_slow;
    } cbsel_core_t;

endpackage

// ### cbsel_clk_gen.sv
// Fractional clock generator for the three clock-output pin functions
`timescale 1ns/1ps
`include "cbsel_regs.svh"

module cbsel_clk_gen (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic run, // Low freezes all clocks
    output logic clk_fast_q, // Fast clock output
    output logic clk_mid_q, // Fast divided by two
    output logic clk_slow_q // Fast divided by four
);
    localparam logic [`CBSEL_ACC_W-1:0] STEP = `CBSEL_ACC_W'(2 * `CBSEL_FAST_MHZ);
    localparam logic [`CBSEL_ACC_W:0] WRAP = (`CBSEL_ACC_W + 1)'(`CBSEL_CLK_MHZ);

    logic [`CBSEL_ACC_W-1:0] acc_q;
    logic [`CBSEL_ACC_W:0] sum;
    logic hit;

    assign sum = {1'b0, acc_q} + {1'b0, STEP};
    assign hit = run && (sum >= WRAP);

    // ==========================================================
    // Phase accumulator, held while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= '0;
        end else if (run) begin
            acc_q <= hit ? `CBSEL_ACC_W'(sum - WRAP) : sum[`CBSEL_ACC_W-1:0];
        end
    end

    // ==========================================================
    // Toggle chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_fast_q <= 1'b0;
            clk_mid_q <= 1'b0;
            clk_slow_q <= 1'b0;
        end else if (hit) begin
            clk_fast_q <= ~clk_fast_q;
            if (!clk_fast_q) begin
                clk_mid_q <= ~clk_mid_q;
                if (!clk_mid_q) begin
                    clk_slow_q <= ~clk_slow_q;
                end
            end
        end
    end
endmodule

// ### cbsel_pin_drv.sv
// Output stage of one configurable pin
`timescale 1ns/1ps

module cbsel_pin_drv (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire cbsel_pkg::cbsel_func_t func, // Selected function
    input wire cbsel_pkg::cbsel_core_t core, // Device state
    input wire logic gpio_out, // Software output level
    input wire logic gpio_dir, // Software direction, 1 drives
    output logic pad_out_q, // Pad output level
    output logic pad_oe_q // Pad output enable
);
    logic out_d;
    logic oe_d;

    always_comb begin
        out_d = 1'b0;
        oe_d = 1'b0;
        case (func)
            cbsel_pkg::FN_RS485_TXEN: begin
                out_d = core.rs485_txen;
                oe_d = 1'b1;
            end
            cbsel_pkg::FN_DRIVE_1: begin
                out_d = 1'b1;
                oe_d = 1'b1;
            end
            cbsel_pkg::FN_DRIVE_0: begin
                oe_d = 1'b1;
            end
            cbsel_pkg::FN_PWR_SWITCH_N: begin
                oe_d = core.configured && !core.suspend;
            end
            cbsel_pkg::FN_TX_LED_N: begin
                oe_d = core.tx_led;
            end
            cbsel_pkg::FN_RX_LED_N: begin
                oe_d = core.rx_led;
            end
            cbsel_pkg::FN_ANY_LED_N: begin
                oe_d = core.tx_led || core.rx_led;
            end
            cbsel_pkg::FN_SLEEP_N: begin
                out_d = !core.suspend || (core.cancel_sleep && core.charger);
                oe_d = 1'b1;
            end
            cbsel_pkg::FN_CLK_FAST: begin
                out_d = core.clk_fast;
                oe_d = 1'b1;
            end
            cbsel_pkg::FN_CLK_MID: begin
                out_d = core.clk_mid;
                oe_d = 1'b1;
            end
            cbsel_pkg::FN_CLK_SLOW: begin
                out_d = core.clk_slow;
                oe_d = 1'b1;
            end
            cbsel_pkg::FN_GPIO: begin
                out_d = gpio_out;
                oe_d = gpio_dir;
            end
            cbsel_pkg::FN_CHG_HI: begin
                out_d = core.charger;
                oe_d = 1'b1;
            end
            cbsel_pkg::FN_CHG_LO_N: begin
                oe_d = core.charger;
            end
            cbsel_pkg::FN_WR_STROBE_N: begin
                out_d = core.wr_strobe_n;
                oe_d = 1'b1;
            end
            cbsel_pkg::FN_RD_STROBE_N: begin
                out_d = core.rd_strobe_n;
                oe_d = 1'b1;
            end
            cbsel_pkg::FN_TIMESTAMP: begin
                out_d = core.tstamp;
                oe_d = 1'b1;
            end
            default: begin
                oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out_q <= 1'b0;
            pad_oe_q <= 1'b0;
        end else begin
            pad_out_q <= out_d;
            pad_oe_q <= oe_d;
        end
    end
endmodule

// ### cbsel_ext_model.sv
// Board pull-ups and external drivers on the four configurable pins
`timescale 1ns/1ps

module cbsel_ext_model (
    input wire logic [3:0] pin_out, // Device pad levels
    input wire logic [3:0] pin_oe, // Device pad enables
    input wire logic [3:0] ext_en, // External driver enables
    input wire logic [3:0] ext_lvl, // External driven levels
    output logic [3:0] pad // Resolved pad levels
);
    // Pull-up wins when nobody drives
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pad[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_lvl[i] : 1'b1);
        end
    end
endmodule

// ### testbench.sv
// Register-level and pin-level test of the pin function mux
`timescale 1ns/1ps

module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic nv_load = 0, nv_cancel_sleep = 0, usb_configured = 0, usb_suspend_req = 0;
    logic usb_tx_act = 0, usb_rx_act = 0, usb_sof = 0, charger_port = 0, rs485_tx_active = 0;
    logic bb_wr_strobe_n = 1, bb_rd_strobe_n = 1, suspend_active, bus_power_present, er, p0;
    logic [19:0] nv_func_sel = 20'h00000;
    logic [3:0] pin_out, pin_oe, pad, ext_en = 4'h0, ext_lvl = 4'h0;
    int fail_count = 0, cmp_count = 0;
    always #2.5 pclk = ~pclk;
    cbsel_mux u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nv_load(nv_load), .nv_func_sel(nv_func_sel),
        .nv_cancel_sleep(nv_cancel_sleep), .usb_configured(usb_configured),
        .usb_suspend_req(usb_suspend_req), .usb_tx_act(usb_tx_act), .usb_rx_act(usb_rx_act),
        .usb_sof(usb_sof), .charger_port(charger_port), .rs485_tx_active(rs485_tx_active),
        .bb_wr_strobe_n(bb_wr_strobe_n), .bb_rd_strobe_n(bb_rd_strobe_n),
        .config_pin_in(pad), .config_pin_out(pin_out), .config_pin_oe(pin_oe),
        .suspend_active(suspend_active), .bus_power_present(bus_power_present));
    cbsel_ext_model u_ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_lvl(ext_lvl), .pad(pad));
    // ==========================================================
    // Tasks
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR t=%0t %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 20) begin
            chk(1'b0, "bus timeout");
            print_verdict();
        end
    endtask
    function automatic logic [31:0] fn4(input cbsel_pkg::cbsel_func_t a, b, c, d);
        return {12'h000, d, c, b, a};
    endfunction
    task automatic cfg(input logic [31:0] f);
        apb(1, 12'h000, f);
        repeat (4) @(posedge pclk);
    endtask
    task automatic pins(input logic [3:0] ep, eo, input string m);
        repeat (4) @(posedge pclk);
        chk(pad === ep && pin_oe === eo, m);
    endtask
    task automatic clocks(input logic susp);
        int tg[3];
        tg = '{0, 0, 0};
        for (int k = 0; k < 1000; k++) begin
            p0 = pad[0];
            rd[2:0] = pad[2:0];
            @(posedge pclk);
            #1;
            for (int i = 0; i < 3; i++) tg[i] += (pad[i] !== rd[i]);
        end
        for (int i = 0; i < 3; i++) begin
            chk(susp ? tg[i] == 0 : (tg[i] >= (240 >> i) - 3 && tg[i] <= (240 >> i) + 3),
                "clock toggle count");
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk(pin_oe === 4'h0, "pins driven after reset");
        nv_func_sel <= fn4(cbsel_pkg::FN_DRIVE_1, cbsel_pkg::FN_DRIVE_0,
            cbsel_pkg::FN_TRISTATE, cbsel_pkg::FN_DRIVE_1);
        nv_load <= 1;
        @(posedge pclk);
        nv_load <= 0;
        apb(0, 12'h000, 0);
        chk(rd[19:0] === nv_func_sel, "stored functions");
        pins(4'b1101, 4'b1011, "constant and tristate");
        apb(0, 12'h010, 0);
        chk(er === 1'b1 && rd === 32'h0, "unmapped read");
        cfg(fn4(cbsel_pkg::FN_PWR_SWITCH_N, cbsel_pkg::FN_SLEEP_N, cbsel_pkg::FN_CHG_HI,
            cbsel_pkg::FN_CHG_LO_N));
        pins(4'b1011, 4'b0110, "unconfigured idle");
        usb_configured <= 1;
        charger_port <= 1;
        pins(4'b0110, 4'b1111, "configured on charger");
        usb_suspend_req <= 1;
        pins(4'b0101, 4'b1110, "suspend");
        chk(suspend_active === 1'b1, "suspend flag");
        apb(0, 12'h00C, 0);
        chk(rd === 32'h000000F5, "status in suspend");
        apb(1, 12'h004, 32'h1);
        pins(4'b0111, 4'b1110, "sleep cancelled on charger");
        usb_suspend_req <= 0;
        charger_port <= 0;
        cfg(fn4(cbsel_pkg::FN_KEEP_AWAKE_N, cbsel_pkg::FN_BUS_SENSE,
            cbsel_pkg::FN_RS485_TXEN, cbsel_pkg::FN_WR_STROBE_N));
        ext_en <= 4'b0011;
        rs485_tx_active <= 1;
        bb_wr_strobe_n <= 0;
        usb_suspend_req <= 1;
        pins(4'b0100, 4'b1100, "inputs, enable, strobe");
        chk(suspend_active === 1'b0 && bus_power_present === 1'b0, "keep awake");
        ext_lvl <= 4'b0011;
        repeat (4) @(posedge pclk);
        chk(suspend_active === 1'b1 && bus_power_present === 1'b1, "awake released");
        usb_suspend_req <= 0;
        cfg(fn4(cbsel_pkg::FN_TX_LED_N, cbsel_pkg::FN_RX_LED_N, cbsel_pkg::FN_ANY_LED_N,
            cbsel_pkg::FN_RD_STROBE_N));
        bb_rd_strobe_n <= 0;
        usb_tx_act <= 1;
        @(posedge pclk);
        usb_tx_act <= 0;
        pins(4'b0010, 4'b1101, "transmit pulse");
        repeat (2010) @(posedge pclk);
        usb_rx_act <= 1;
        @(posedge pclk);
        usb_rx_act <= 0;
        pins(4'b0001, 4'b1110, "receive pulse");
        repeat (2010) @(posedge pclk);
        chk(pin_oe === 4'b1000, "pulses ended");
        cfg(fn4(cbsel_pkg::FN_TIMESTAMP, cbsel_pkg::FN_GPIO, cbsel_pkg::FN_GPIO,
            cbsel_pkg::FN_GPIO));
        apb(1, 12'h008, 32'h62);
        p0 = pad[0];
        usb_sof <= 1;
        @(posedge pclk);
        usb_sof <= 0;
        pins({3'b101, ~p0}, 4'b0111, "timestamp and gpio");
        cfg(fn4(cbsel_pkg::FN_CLK_FAST, cbsel_pkg::FN_CLK_MID, cbsel_pkg::FN_CLK_SLOW,
            cbsel_pkg::FN_TRISTATE));
        clocks(1'b0);
        usb_suspend_req <= 1;
        repeat (4) @(posedge pclk);
        clocks(1'b1);
        print_verdict();
    end
endmodule
